// file: verilog/crxbf_defines.svh
// Register map, field positions, reset values for the receive buffer control block
`ifndef CRXBF_DEFINES_SVH
`define CRXBF_DEFINES_SVH

`define CRXBF_ADDR_W 12
`define CRXBF_A_TX_BUF2_CONTROL 12'hf20
`define CRXBF_A_TX_BUF2_LENGTH 12'hf25
`define CRXBF_A_STAT_MC 12'hf2e
`define CRXBF_A_TX_BUF1_CONTROL 12'hf30
`define CRXBF_A_TX_BUF1_LENGTH 12'hf35
`define CRXBF_A_STAT_MB 12'hf3e
`define CRXBF_A_TX_BUF0_CONTROL 12'hf40
`define CRXBF_A_TX_BUF0_LENGTH 12'hf45
`define CRXBF_A_STAT_MA 12'hf4e
`define CRXBF_A_RX_BUF1_CONTROL 12'hf50
`define CRXBF_A_RX_BUF1_LENGTH 12'hf55
`define CRXBF_A_STAT_M0 12'hf5e
`define CRXBF_A_RX_BUF0_CONTROL 12'hf60
`define CRXBF_A_RX_BUF0_LENGTH 12'hf65
`define CRXBF_A_STAT 12'hf6e
`define CRXBF_A_CTRL 12'hf6f
`define CRXBF_A_BRG1 12'hf70
`define CRXBF_A_BRG2 12'hf71
`define CRXBF_A_BRG3 12'hf72
`define CRXBF_A_PINCTL 12'hf73
`define CRXBF_A_COMM_STATUS 12'hf74
`define CRXBF_A_RXERR 12'hf75
`define CRXBF_A_TXERR 12'hf76
`define CRXBF_A_MODECTL 12'hf77
// Locations of our own choosing for unprinted registers
`define CRXBF_A_PBCON_BASE 12'hde0
`define CRXBF_A_PBDLC_BASE 12'hde8
`define CRXBF_A_FEN_LO 12'hdf0
`define CRXBF_A_FEN_HI 12'hdf1
`define CRXBF_A_DFLC 12'hdf2
`define CRXBF_A_BUFDIR 12'hdf3
`define CRXBF_BLK_LO 12'hf00
`define CRXBF_BLK_HI 12'hf7f

`define CRXBF_BIT_FULL 7
`define CRXBF_BIT_ACCALL 6
`define CRXBF_BIT_RTR 5
`define CRXBF_BIT_RTRLEN 6
`define CRXBF_MODE_MSB 7
`define CRXBF_MODE_LSB 6
`define CRXBF_CFG_MSB 7

`define CRXBF_RST_FEN_LO 8'h3f
`define CRXBF_RST_FEN_HI 8'h10
`define CRXBF_RST_CTRL 8'h80
`define CRXBF_RST_BYTE 8'h00
`define CRXBF_DLC_MAX 4'h8
`define CRXBF_PASSIVE_LIM 8'h7f
`define CRXBF_BITS_DLC1 5'h08
`define CRXBF_BITS_DLC2 5'h10
`define CRXBF_BITS_DLC3 5'h12

`endif

// file: verilog/crxbf_pkg.sv
// Types shared by the receive buffer control block
package crxbf_pkg;
    typedef logic [7:0] crxbf_byte_t;
    typedef logic [1:0] crxbf_mode_t;
    typedef logic [3:0] crxbf_hit_t;
endpackage

// file: verilog/crxbf_slot.sv
// One programmable message buffer: control and length state
`timescale 1ns/1ns
`include "crxbf_defines.svh"
module crxbf_slot
    import crxbf_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // Store request
    input wire logic i_store,
    input wire logic i_rtr,
    input wire crxbf_hit_t i_hit,
    input wire logic [3:0] i_dlc,
    // Software access
    input wire logic i_acc_wr,
    input wire logic i_full_wr,
    input wire crxbf_byte_t i_wdata,
    // State
    output logic o_full,
    output logic o_accept_all,
    output crxbf_byte_t o_con,
    output crxbf_byte_t o_dlc
);
    import crxbf_pkg::*;
    logic full_reg;
    logic acc_reg;
    logic rtr_reg;
    crxbf_hit_t hit_reg;
    logic [3:0] dlc_reg;
    wire take = i_store & ~full_reg;

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            full_reg <= 1'b0;
            acc_reg <= 1'b0;
            rtr_reg <= 1'b0;
            hit_reg <= 4'h0;
            dlc_reg <= 4'h0;
        end else begin
            // Store wins over a software clear in the same cycle
            if (take) begin
                full_reg <= 1'b1; // [RL4]
            end else if (i_full_wr && !i_wdata[`CRXBF_BIT_FULL]) begin
                full_reg <= 1'b0;
            end
            if (i_acc_wr) begin
                acc_reg <= i_wdata[`CRXBF_BIT_ACCALL]; // [RL5]
            end
            if (take) begin
                rtr_reg <= i_rtr; // [RL6]
                hit_reg <= i_hit; // [RL7]
                dlc_reg <= i_dlc;
            end
        end
    end

    assign o_full = full_reg;
    assign o_accept_all = acc_reg;
    assign o_con = {full_reg, acc_reg, rtr_reg, 1'b0, hit_reg}; // [RL7]
    assign o_dlc = {1'b0, rtr_reg, 2'b00, dlc_reg}; // [RL8] [RL9]

    AST_FULL_HOLDS: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [RL4]
        full_reg && !i_full_wr |=> full_reg)
        else $error("full flag dropped without clear");
    // Any full cycle must freeze the stored message, whatever the store input does
    AST_NO_RELOAD: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [RL4]
        full_reg |=> $stable(dlc_reg) && $stable(hit_reg) && $stable(rtr_reg))
        else $error("full buffer was overwritten");
endmodule

// file: verilog/crxbf_errcnt.sv
// Receive error counter with error-passive detection
`timescale 1ns/1ns
`include "crxbf_defines.svh"
module crxbf_errcnt
    import crxbf_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // Error events
    input wire logic i_inc,
    input wire logic i_inc8,
    input wire logic i_dec,
    // State
    output crxbf_byte_t o_count,
    output logic o_passive
);
    import crxbf_pkg::*;
    logic [8:0] cnt_reg;
    logic [8:0] cnt_next;
    wire [8:0] add_amt = i_inc8 ? 9'h008 : 9'h001;
    wire [8:0] sum = cnt_reg + add_amt;

    // Saturate at byte range; counter alone never forces bus-off
    always_comb begin
        cnt_next = cnt_reg;
        if (i_inc || i_inc8) begin
            cnt_next = (sum > 9'h0ff) ? 9'h0ff : sum;
        end else if (i_dec && cnt_reg != 9'h000) begin
            cnt_next = cnt_reg - 9'h001;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            cnt_reg <= 9'h000;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign o_count = cnt_reg[7:0];
    assign o_passive = (cnt_reg[7:0] > `CRXBF_PASSIVE_LIM); // [RL17]

    AST_PASSIVE: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [RL17]
        o_passive == (o_count >= 8'h80))
        else $error("error passive threshold wrong");
endmodule

// file: verilog/crxbf_top.sv
// Receive control of six programmable buffers, filter enables, register map
// Contract
// [RL1] Six buffers, each transmit or receive
// [RL2] Programmable registers only in modes 1, 2; code also enables them in mode 3
// [RL3] Transmit-select zero means receive buffer layout
// [RL4] Full set on store, blocks reload
// [RL5] Accept-all takes everything, bypasses filters
// [RL6] Control bit shows remote request
// [RL7] Five-bit field holds accepting filter number
// [RL8] Length bits 7, 5, 4 read zero
// [RL9] Length bit 6 shows remote request
// [RL10] Length code 0..8 valid, above reserved
// [RL11] Sixteen filter enables in two registers
// [RL12] Filter length writable only in configuration
// [RL13] Filter length five bits, zero in mode 0
// [RL14] Compared bits bounded by length code; code leaves reserved codes uncapped at the full filter length
// [RL15] Status mirrored at four more addresses
// [RL16] Unimplemented block addresses read zero
// [RL17] Error counter over 127 gives passive
// [RL18] Software clears full after reading all
`timescale 1ns/1ns
`include "crxbf_defines.svh"
module crxbf_top
    import crxbf_pkg::*;
#(
    parameter int NBUF = 6
)(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // Register port
    input wire logic [`CRXBF_ADDR_W-1:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire crxbf_pkg::crxbf_byte_t i_wdata,
    output crxbf_pkg::crxbf_byte_t o_rdata,
    output logic o_rvalid,
    // Received frame from protocol engine
    input wire logic i_msg_done,
    input wire logic i_msg_valid,
    input wire logic i_msg_rtr,
    input wire logic [3:0] i_msg_dlc,
    input wire logic [15:0] i_filter_match,
    // Protocol engine status
    input wire crxbf_pkg::crxbf_byte_t i_opmode,
    input wire crxbf_pkg::crxbf_byte_t i_comm_status,
    input wire crxbf_pkg::crxbf_byte_t i_tx_errcnt,
    input wire logic i_rx_err,
    input wire logic i_rx_err8,
    input wire logic i_rx_ok,
    // Configuration outputs to engine
    output logic [15:0] o_filter_en,
    output logic [4:0] o_cmp_bits,
    output logic [NBUF-1:0] o_buf_full,
    output logic o_err_passive,
    output logic o_cfg_mode
);
    import crxbf_pkg::*;

    crxbf_byte_t ctrl_reg;
    crxbf_byte_t modectl_reg;
    crxbf_byte_t brg1_reg;
    crxbf_byte_t brg2_reg;
    crxbf_byte_t brg3_reg;
    crxbf_byte_t pinctl_reg;
    crxbf_byte_t fen_lo_reg;
    crxbf_byte_t fen_hi_reg;
    logic [4:0] dflc_reg;
    logic [NBUF-1:0] dir_reg;
    crxbf_byte_t rdata_reg;
    logic rvalid_reg;
    logic [4:0] cmp_reg;
    logic passive_reg;
    logic [NBUF-1:0] full_out_reg;
    crxbf_byte_t rdata_next;

    wire crxbf_mode_t mode = modectl_reg[`CRXBF_MODE_MSB:`CRXBF_MODE_LSB];
    wire enh = (mode != 2'b00); // [RL2]
    wire cfg = ctrl_reg[`CRXBF_CFG_MSB];
    wire [15:0] fen = {fen_hi_reg, fen_lo_reg}; // [RL11]

    // Lowest enabled matching filter wins
    logic [3:0] hit_idx;
    logic hit_any;
    always_comb begin
        hit_idx = 4'h0;
        hit_any = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            if (i_filter_match[i] && fen[i]) begin
                hit_idx = 4'(i);
                hit_any = 1'b1;
            end
        end
    end

    // Pick first free receive buffer that will take this frame
    wire [NBUF-1:0] slot_full;
    wire [NBUF-1:0] slot_accall;
    wire [NBUF-1:0] can_take;
    logic [NBUF-1:0] store_vec;
    genvar g;
    generate
        for (g = 0; g < NBUF; g++) begin : g_take
            assign can_take[g] = ~dir_reg[g] & ~slot_full[g] & // [RL3]
                (slot_accall[g] | (i_msg_valid & hit_any)); // [RL5]
        end
    endgenerate

    always_comb begin
        store_vec = '0;
        for (int i = NBUF - 1; i >= 0; i--) begin
            if (can_take[i]) begin
                store_vec = '0;
                store_vec[i] = i_msg_done & enh;
            end
        end
    end

    // Programmable register decode
    wire in_con = (i_addr >= `CRXBF_A_PBCON_BASE) &&
        (i_addr < `CRXBF_A_PBCON_BASE + 12'(NBUF));
    wire in_dlc = (i_addr >= `CRXBF_A_PBDLC_BASE) &&
        (i_addr < `CRXBF_A_PBDLC_BASE + 12'(NBUF));
    wire [2:0] con_idx = 3'(i_addr - `CRXBF_A_PBCON_BASE);
    wire [2:0] dlc_idx = 3'(i_addr - `CRXBF_A_PBDLC_BASE);
    wire con_wr = i_wr & in_con & enh; // [RL2]
    wire cfg_wr = i_wr & enh & cfg; // [RL12]

    crxbf_byte_t slot_con [NBUF];
    crxbf_byte_t slot_dlc [NBUF];
    generate
        for (g = 0; g < NBUF; g++) begin : g_slot // [RL1]
            wire sel = con_wr && (con_idx == 3'(g)) && !dir_reg[g];
            crxbf_slot u_slot (
                .i_ref_clk(i_ref_clk),
                .i_srst(i_srst),
                .i_store(store_vec[g]),
                .i_rtr(i_msg_rtr),
                .i_hit(hit_idx),
                .i_dlc(i_msg_dlc),
                .i_acc_wr(sel),
                .i_full_wr(sel),
                .i_wdata(i_wdata),
                .o_full(slot_full[g]),
                .o_accept_all(slot_accall[g]),
                .o_con(slot_con[g]),
                .o_dlc(slot_dlc[g])
            );
        end
    endgenerate

    crxbf_byte_t rx_err;
    logic passive_w;
    crxbf_errcnt u_errcnt (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_inc(i_rx_err),
        .i_inc8(i_rx_err8),
        .i_dec(i_rx_ok),
        .o_count(rx_err),
        .o_passive(passive_w)
    );

    // Compared data bits capped by length code; reserved codes are not capped and use the full filter length
    logic [4:0] cap;
    always_comb begin
        case (i_msg_dlc)
            4'h0: cap = 5'h00;
            4'h1: cap = `CRXBF_BITS_DLC1;
            4'h2: cap = `CRXBF_BITS_DLC2;
            default: cap = `CRXBF_BITS_DLC3;
        endcase
    end
    wire [4:0] dflc_eff = enh ? dflc_reg : 5'h00; // [RL13]
    wire [4:0] cmp_next = (dflc_eff < cap) ? dflc_eff : cap; // [RL14]
    wire dlc_reserved = (i_msg_dlc > `CRXBF_DLC_MAX); // [RL10]

    wire crxbf_byte_t stat_val = {i_opmode[7:5], 5'h00};
    wire is_stat = (i_addr == `CRXBF_A_STAT) || (i_addr == `CRXBF_A_STAT_M0) ||
        (i_addr == `CRXBF_A_STAT_MA) || (i_addr == `CRXBF_A_STAT_MB) ||
        (i_addr == `CRXBF_A_STAT_MC); // [RL15]

    // Read mux; anything unmatched reads zero
    always_comb begin
        rdata_next = `CRXBF_RST_BYTE; // [RL16]
        if (is_stat) begin
            rdata_next = stat_val;
        end else if (in_con && enh && con_idx < 3'(NBUF)) begin
            rdata_next = slot_con[con_idx]; // [RL3]
        end else if (in_dlc && enh && dlc_idx < 3'(NBUF)) begin
            rdata_next = slot_dlc[dlc_idx]; // [RL8]
        end else begin
            case (i_addr)
                `CRXBF_A_CTRL: rdata_next = ctrl_reg;
                `CRXBF_A_BRG1: rdata_next = brg1_reg;
                `CRXBF_A_BRG2: rdata_next = brg2_reg;
                `CRXBF_A_BRG3: rdata_next = brg3_reg;
                `CRXBF_A_PINCTL: rdata_next = pinctl_reg;
                `CRXBF_A_COMM_STATUS: rdata_next = i_comm_status;
                `CRXBF_A_RXERR: rdata_next = rx_err;
                `CRXBF_A_TXERR: rdata_next = i_tx_errcnt;
                `CRXBF_A_MODECTL: rdata_next = modectl_reg;
                `CRXBF_A_FEN_LO: rdata_next = enh ? fen_lo_reg : 8'h00;
                `CRXBF_A_FEN_HI: rdata_next = enh ? fen_hi_reg : 8'h00;
                `CRXBF_A_DFLC: rdata_next = {3'b000, dflc_eff}; // [RL13]
                `CRXBF_A_BUFDIR: rdata_next = {2'b00, dir_reg};
                default: rdata_next = `CRXBF_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ctrl_reg <= `CRXBF_RST_CTRL;
            modectl_reg <= `CRXBF_RST_BYTE;
            brg1_reg <= `CRXBF_RST_BYTE;
            brg2_reg <= `CRXBF_RST_BYTE;
            brg3_reg <= `CRXBF_RST_BYTE;
            pinctl_reg <= `CRXBF_RST_BYTE;
            fen_lo_reg <= `CRXBF_RST_FEN_LO;
            fen_hi_reg <= `CRXBF_RST_FEN_HI;
            dflc_reg <= 5'h00;
            dir_reg <= '0;
        end else if (i_wr) begin
            if (i_addr == `CRXBF_A_CTRL) ctrl_reg <= i_wdata;
            if (i_addr == `CRXBF_A_MODECTL) modectl_reg <= i_wdata;
            if (i_addr == `CRXBF_A_BRG1 && cfg) brg1_reg <= i_wdata;
            if (i_addr == `CRXBF_A_BRG2 && cfg) brg2_reg <= i_wdata;
            if (i_addr == `CRXBF_A_BRG3 && cfg) brg3_reg <= i_wdata;
            if (i_addr == `CRXBF_A_PINCTL) pinctl_reg <= i_wdata;
            if (i_addr == `CRXBF_A_FEN_LO && enh) fen_lo_reg <= i_wdata; // [RL11]
            if (i_addr == `CRXBF_A_FEN_HI && enh) fen_hi_reg <= i_wdata; // [RL11]
            if (cfg_wr && i_addr == `CRXBF_A_DFLC) dflc_reg <= i_wdata[4:0]; // [RL12]
            if (i_addr == `CRXBF_A_BUFDIR && enh) dir_reg <= i_wdata[NBUF-1:0];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            rdata_reg <= `CRXBF_RST_BYTE;
            rvalid_reg <= 1'b0;
            cmp_reg <= 5'h00;
            passive_reg <= 1'b0;
            full_out_reg <= '0;
        end else begin
            rdata_reg <= i_rd ? rdata_next : `CRXBF_RST_BYTE;
            rvalid_reg <= i_rd;
            cmp_reg <= dlc_reserved ? dflc_eff : cmp_next; // [RL14]
            passive_reg <= passive_w; // [RL17]
            full_out_reg <= slot_full;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_rvalid = rvalid_reg;
    assign o_filter_en = {fen_hi_reg, fen_lo_reg};
    assign o_cmp_bits = cmp_reg;
    assign o_buf_full = full_out_reg;
    assign o_err_passive = passive_reg;
    assign o_cfg_mode = ctrl_reg[`CRXBF_CFG_MSB];

    // Store path: a taken frame fills the chosen buffer next cycle
    sequence s_frame_in;
        i_msg_done && enh && (|can_take);
    endsequence
    sequence s_one_full;
        ##1 (|(slot_full & ~$past(slot_full)));
    endsequence
    sequence s_accall_free;
        i_msg_done && enh && (|(~dir_reg & ~slot_full & slot_accall));
    endsequence
    AST_STORE_SETS_FULL: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [RL4]
        s_frame_in |-> s_one_full)
        else $error("accepted frame did not fill a buffer");
    AST_ACCALL_TAKES: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [RL5]
        s_accall_free |-> s_one_full)
        else $error("accept-all buffer ignored a frame");
    AST_MODE0_NO_STORE: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [RL2]
        !enh |-> store_vec == '0)
        else $error("store in legacy mode");
    AST_FILTER_GATE: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [RL5]
        (|store_vec) && !(|(store_vec & slot_accall)) |-> i_msg_valid && hit_any)
        else $error("filtered buffer took unmatched frame");
    AST_HIT_LOWEST: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [RL7]
        hit_any |-> fen[hit_idx] && i_filter_match[hit_idx] &&
            (i_filter_match & fen & ((16'h0001 << hit_idx) - 16'h0001)) == 16'h0000)
        else $error("filter hit is not the lowest enabled match");
    AST_TX_NOT_STORED: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [RL3]
        (store_vec & dir_reg) == '0)
        else $error("transmit buffer received a frame");
    AST_DFLC_CFG_ONLY: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [RL12]
        !cfg |=> $stable(dflc_reg))
        else $error("filter length changed outside configuration");
    AST_CMP_BOUND: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [RL14]
        !dlc_reserved |=> o_cmp_bits <= $past(cap))
        else $error("compare count exceeds length bound");

    // Register view
    AST_STAT_MIRROR: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [RL15]
        i_rd && is_stat |=> o_rdata == $past(stat_val) && o_rvalid)
        else $error("status mirror read mismatch");
    AST_MODE0_DFLC: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [RL13]
        i_rd && !enh && i_addr == `CRXBF_A_DFLC |=> o_rdata == 8'h00)
        else $error("filter length not zero in mode 0");
    AST_MODE0_HIDDEN: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [RL2]
        i_rd && !enh && (in_con || in_dlc || i_addr == `CRXBF_A_FEN_LO ||
            i_addr == `CRXBF_A_FEN_HI) |=> o_rdata == 8'h00)
        else $error("programmable register visible in mode 0");
    AST_FEN_FROZEN: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [RL2]
        !enh |=> $stable(fen))
        else $error("filter enables written in mode 0");
    AST_UNMAPPED_ZERO: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [RL16]
        i_rd && i_addr > `CRXBF_A_MODECTL && i_addr <= `CRXBF_BLK_HI |=> o_rdata == 8'h00)
        else $error("unimplemented address read nonzero");
    // Read data is zero between reads so a stale byte never looks fresh
    AST_IDLE_RDATA: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        !i_rd |=> o_rdata == 8'h00 && !o_rvalid)
        else $error("read data or valid outside a read");
    AST_PASSIVE_OUT: assert property (@(posedge i_ref_clk) disable iff (i_srst) // [RL17]
        rx_err >= 8'h80 |=> o_err_passive)
        else $error("error passive output missing");

    // Per-buffer capture of a stored frame, and transmit buffers left alone
    generate
        for (g = 0; g < NBUF; g++) begin : g_chk
            AST_SLOT_CAPTURE: assert property ( // [RL6] [RL7]
                @(posedge i_ref_clk) disable iff (i_srst)
                store_vec[g] |=> slot_con[g][`CRXBF_BIT_RTR] == $past(i_msg_rtr) &&
                    slot_con[g][4:0] == {1'b0, $past(hit_idx)})
                else $error("stored remote flag or filter hit wrong");
            AST_SLOT_LENGTH: assert property ( // [RL8] [RL9] [RL10]
                @(posedge i_ref_clk) disable iff (i_srst)
                store_vec[g] |=> slot_dlc[g] ==
                    {1'b0, $past(i_msg_rtr), 2'b00, $past(i_msg_dlc)})
                else $error("stored length byte wrong");
            AST_TX_FROZEN: assert property ( // [RL3]
                @(posedge i_ref_clk) disable iff (i_srst)
                dir_reg[g] |=> $stable(slot_full[g]) && $stable(slot_accall[g]))
                else $error("transmit buffer receive state changed");
        end
    endgenerate
endmodule

// file: test/crxbf_engine_model.sv
// Frame source standing in for the protocol engine
`timescale 1ns/1ns
module crxbf_engine_model (
    // Clock
    input wire logic i_clk,
    // Frame outputs
    output logic o_done,
    output logic o_valid,
    output logic o_rtr,
    output logic [3:0] o_dlc,
    output logic [15:0] o_match
);
    initial begin
        o_done = 1'b0;
        o_valid = 1'b0;
        o_rtr = 1'b0;
        o_dlc = 4'h0;
        o_match = 16'h0000;
    end

    // Fields only qualify the done cycle; inverted after it so stale values never repeat the done-cycle values
    task automatic send(input logic v, input logic r, input logic [3:0] d,
                        input logic [15:0] m);
        @(negedge i_clk);
        o_done = 1'b1;
        o_valid = v;
        o_rtr = r;
        o_dlc = d;
        o_match = m;
        @(negedge i_clk);
        o_done = 1'b0;
        o_valid = ~v;
        o_rtr = ~r;
        o_dlc = ~d;
        o_match = ~m;
    endtask
endmodule

// file: test/testbench.sv
// Self-checking bench for the receive buffer control block
`timescale 1ns/1ns
`include "crxbf_defines.svh"
module testbench;
    import crxbf_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [11:0] addr = 12'h000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    crxbf_byte_t wdata = 8'h00;
    crxbf_byte_t rdata;
    logic rvalid;
    logic done, valid, rtr;
    logic [3:0] dlc;
    logic [15:0] match;
    crxbf_byte_t opmode = 8'ha5;
    logic rx_err = 1'b0;
    logic rx_err8 = 1'b0;
    logic rx_ok = 1'b0;
    logic [15:0] filter_en;
    logic [4:0] cmp_bits;
    logic [5:0] buf_full;
    logic err_passive, cfg_mode;
    int failures = 0;
    int n_tests = 0;

    always #10 clk = ~clk;

    crxbf_engine_model u_eng (.i_clk(clk), .o_done(done), .o_valid(valid), .o_rtr(rtr),
        .o_dlc(dlc), .o_match(match));

    crxbf_top #(.NBUF(6)) i_dut (.i_ref_clk(clk), .i_srst(srst), .i_addr(addr), .i_wr(wr),
        .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid), .i_msg_done(done),
        .i_msg_valid(valid), .i_msg_rtr(rtr), .i_msg_dlc(dlc), .i_filter_match(match),
        .i_opmode(opmode), .i_comm_status(8'h3c), .i_tx_errcnt(8'h5a), .i_rx_err(rx_err),
        .i_rx_err8(rx_err8), .i_rx_ok(rx_ok), .o_filter_en(filter_en), .o_cmp_bits(cmp_bits),
        .o_buf_full(buf_full), .o_err_passive(err_passive), .o_cfg_mode(cfg_mode));

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [11:0] a, input crxbf_byte_t d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask

    // Answer stands one cycle only, so it is judged at the very next falling edge
    task automatic rd_reg(input logic [11:0] a, input crxbf_byte_t exp);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        chk($sformatf("rvalid %h", a), 16'h0001, {15'h0000, rvalid});
        chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, rdata});
    endtask

    task automatic store(input logic v, input logic [3:0] d, input int idx,
                         input crxbf_byte_t con);
        u_eng.send(v, 1'b0, d, 16'h0808);
        @(negedge clk);
        chk("buf_full bit", 16'h0001, {15'h0000, buf_full[idx]});
        rd_reg(12'hde0 + 12'(idx), con);
    endtask

    // Programmable registers stay hidden and unwritable in mode 0
    task automatic t_reset();
        chk("filter_en", 16'h103f, filter_en);
        chk("cfg_mode", 16'h0001, {15'h0000, cfg_mode});
        chk("buf_full", 16'h0000, {10'h000, buf_full});
        rd_reg(12'hdf0, 8'h00);
        rd_reg(12'hdf1, 8'h00);
        rd_reg(12'hf6f, 8'h80);
        rd_reg(12'hf7d, 8'h00);
        wr_reg(12'hdf0, 8'h00);
        chk("filter_en", 16'h103f, filter_en);
        rd_reg(12'hdf0, 8'h00);
    endtask

    task automatic t_filter();
        logic [3:0] dl[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
        int exp_bits[6] = '{0, 8, 16, 18, 18, 31};
        wr_reg(12'hf77, 8'h40);
        rd_reg(12'hdf0, 8'h3f);
        rd_reg(12'hdf1, 8'h10);
        wr_reg(12'hdf0, 8'h00);
        wr_reg(12'hdf1, 8'h08);
        rd_reg(12'hdf1, 8'h08);
        chk("filter_en", 16'h0800, filter_en);
        wr_reg(12'hdf2, 8'hff);
        rd_reg(12'hdf2, 8'h1f);
        for (int d = 0; d < 6; d++) begin
            u_eng.send(1'b1, 1'b0, dl[d], 16'h0000);
            chk("cmp_bits", 16'(exp_bits[d]), {11'h000, cmp_bits});
        end
        wr_reg(12'hf6f, 8'h00);
        chk("cfg_mode", 16'h0000, {15'h0000, cfg_mode});
        wr_reg(12'hdf2, 8'h03);
        rd_reg(12'hdf2, 8'h1f);
    endtask

    task automatic t_store();
        u_eng.send(1'b1, 1'b1, 4'h8, 16'h0808);
        @(negedge clk);
        chk("buf_full", 16'h0001, {10'h000, buf_full});
        rd_reg(12'hde0, 8'hab);
        rd_reg(12'hde8, 8'h48);
        u_eng.send(1'b1, 1'b0, 4'h2, 16'h0004);
        store(1'b1, 4'h1, 1, 8'h8b);
        wr_reg(12'hde2, 8'h40);
        store(1'b0, 4'h0, 2, 8'hcb);
        rd_reg(12'hdea, 8'h00);
        wr_reg(12'hdf3, 8'h08);
        store(1'b1, 4'h0, 4, 8'h8b);
        store(1'b1, 4'h0, 5, 8'h8b);
        u_eng.send(1'b1, 1'b0, 4'h0, 16'h0808);
        @(negedge clk);
        @(negedge clk);
        chk("buf_full", 16'h0037, {10'h000, buf_full});
        wr_reg(12'hde0, 8'h00);
        store(1'b1, 4'h3, 0, 8'h8b);
        rd_reg(12'hde8, 8'h03);
    endtask

    task automatic t_status();
        logic [11:0] mir[5] = '{12'hf6e, 12'hf5e, 12'hf4e, 12'hf3e, 12'hf2e};
        foreach (mir[i]) begin
            rd_reg(mir[i], 8'ha0);
        end
        rd_reg(12'hf74, 8'h3c);
        rd_reg(12'hf76, 8'h5a);
    endtask

    task automatic t_errcnt();
        repeat (15) begin
            @(negedge clk);
            rx_err8 = 1'b1;
            @(negedge clk);
            rx_err8 = 1'b0;
        end
        repeat (7) begin
            @(negedge clk);
            rx_err = 1'b1;
            @(negedge clk);
            rx_err = 1'b0;
        end
        rd_reg(12'hf75, 8'h7f);
        chk("err_passive", 16'h0000, {15'h0000, err_passive});
        @(negedge clk);
        rx_err = 1'b1;
        @(negedge clk);
        rx_err = 1'b0;
        rd_reg(12'hf75, 8'h80);
        chk("err_passive", 16'h0001, {15'h0000, err_passive});
        @(negedge clk);
        rx_ok = 1'b1;
        @(negedge clk);
        rx_ok = 1'b0;
        rd_reg(12'hf75, 8'h7f);
        chk("err_passive", 16'h0000, {15'h0000, err_passive});
        wr_reg(12'hf77, 8'h00);
        rd_reg(12'hdf2, 8'h00);
    endtask

    // Whole run is under two hundred cycles; timeout at 5000 cycles leaves generous margin before giving up
    initial begin
        #(20 * 5000);
        failures++;
        test_done();
    end

    initial begin
        repeat (8) @(negedge clk);
        srst = 1'b0;
        t_reset();
        t_filter();
        t_store();
        t_status();
        t_errcnt();
        test_done();
    end
endmodule
